// *** verilog/label_term_defines.svh ***
// Summary of operation
// - After reset or initialize, terminator is end-of-text, code 3.
// - The first character after define-terminator becomes the new terminator.
// - Null or escape given: command ignored, no error, terminator kept.
// - Line feed or semicolon given: terminator restored to code 3, no error.
// - Printing terminator ends the label and is also drawn.
// - Control terminator ends the label and performs its usual control function, except code 3, which only ends it.
// - Terminator persists until redefined, initialized or defaulted.
// - Label text of all three label commands ends only at the active terminator or an initialize.
// - Extra characters after define-terminator raise error 2; first is kept.
// - Cell height is twice the uppercase character height.
// - Fixed-space cell width is 1.5 times the character width.
// - Variable-space average cell width is 1.5 times the average width.
// - Cell origin and character origin sit at the lower-left corner.
// - Missing terminator: every later byte stays label text, printing ones drawn and control ones executed, until an initialize.
`ifndef LABEL_TERM_DEFINES_SVH
`define LABEL_TERM_DEFINES_SVH
`define TERM_DEFAULT   8'h03
`define CHAR_NULL      8'h00
`define CHAR_LF        8'h0a
`define CHAR_ESC       8'h1b
`define CHAR_SEMI      8'h3b
`define CHAR_SPACE     8'h20
`define CHAR_DEL       8'h7f
`define ERR_PARAM      4'h2
`define CELL_ORIGIN_X  16'h0000
`define CELL_ORIGIN_Y  16'h0000
`endif

// *** verilog/label_term_pkg.sv ***
package label_term_pkg;
  typedef enum logic [2:0] {
    OP_NONE, OP_LABEL, OP_BUF_LABEL, OP_DISP_LABEL, OP_DEF_TERM, OP_INIT
  } op_type;
  typedef enum logic [1:0] {ST_IDLE, ST_TEXT, ST_DT_ARG, ST_DT_EXTRA} st_type;
endpackage : label_term_pkg

// *** verilog/cell_geometry.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "label_term_defines.svh"
module cell_geometry #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] char_w,
  input  wire logic [W-1:0] char_h,
  output logic      [W+1:0] cell_w,
  output logic      [W+1:0] cell_h,
  output logic      [W-1:0] org_x,
  output logic      [W-1:0] org_y
);
  // Width times 1.5 kept exact as three half units; fixed or average same
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cell_w <= '0;
      cell_h <= '0;
      org_x  <= '0;
      org_y  <= '0;
    end else if (ce) begin
      cell_w <= {2'b00, char_w} + {1'b0, char_w, 1'b0};
      cell_h <= {1'b0, char_h, 1'b0};
      org_x  <= W'(`CELL_ORIGIN_X);
      org_y  <= W'(`CELL_ORIGIN_Y);
    end
  end
  property p_cell_h;
    @(posedge clk) disable iff (!rst_n)
    ce |=> cell_h == 2 * $past(char_h);
  endproperty
  a_cell_h: assert property (p_cell_h)
    else $error("cell height not double");
  property p_cell_w;
    @(posedge clk) disable iff (!rst_n)
    ce |=> cell_w == 3 * $past(char_w);
  endproperty
  a_cell_w: assert property (p_cell_w)
    else $error("cell width not 1.5x in half units");
endmodule : cell_geometry
`default_nettype wire

// *** verilog/label_terminator_cell.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "label_term_defines.svh"
module label_terminator_cell
  import label_term_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         CLK,
  input  wire logic         RST_N,
  input  wire logic         CE,
  input  wire logic         OP_VALID,
  input  wire op_type       OP_CODE,
  input  wire logic         BYTE_VALID,
  input  wire logic [7:0]   BYTE_DATA,
  input  wire logic         CMD_END,
  input  wire logic [W-1:0] CHAR_WIDTH,
  input  wire logic [W-1:0] CHAR_HEIGHT,
  output logic      [7:0]   TERMINATOR,
  output logic              IN_LABEL,
  output logic              DRAW_VALID,
  output logic      [7:0]   DRAW_CHAR,
  output logic              CTRL_VALID,
  output logic      [7:0]   CTRL_CHAR,
  output logic              LABEL_DONE,
  output logic              ERR_VALID,
  output logic      [3:0]   ERR_CODE,
  output logic      [W+1:0] CELL_WIDTH_HALF,
  output logic      [W+1:0] CELL_HEIGHT,
  output logic      [W-1:0] ORIGIN_X,
  output logic      [W-1:0] ORIGIN_Y
);
  // ==========================================================
  // Command sequencing
  st_type st_reg;
  logic   is_term;
  logic   printing;
  assign is_term  = BYTE_VALID && BYTE_DATA == TERMINATOR;
  assign printing = BYTE_DATA >= `CHAR_SPACE && BYTE_DATA != `CHAR_DEL;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= ST_IDLE;
    end else if (CE) begin
      if (OP_VALID && OP_CODE == OP_INIT) begin
        st_reg <= ST_IDLE;
      end else begin
        unique case (st_reg)
          ST_IDLE: begin
            if (OP_VALID && (OP_CODE == OP_LABEL || OP_CODE == OP_BUF_LABEL
                || OP_CODE == OP_DISP_LABEL))
              st_reg <= ST_TEXT;
            else if (OP_VALID && OP_CODE == OP_DEF_TERM)
              st_reg <= ST_DT_ARG;
          end
          // Only the terminator ends text; CMD_END is ignored here
          ST_TEXT: if (is_term) st_reg <= ST_IDLE;
          ST_DT_ARG: begin
            if (CMD_END) st_reg <= ST_IDLE;
            else if (BYTE_VALID) st_reg <= ST_DT_EXTRA;
          end
          ST_DT_EXTRA: if (CMD_END) st_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Terminator register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TERMINATOR <= `TERM_DEFAULT;
    end else if (CE) begin
      if (OP_VALID && OP_CODE == OP_INIT) begin
        TERMINATOR <= `TERM_DEFAULT;
      end else if (st_reg == ST_DT_ARG && BYTE_VALID && !CMD_END) begin
        if (BYTE_DATA == `CHAR_LF || BYTE_DATA == `CHAR_SEMI)
          TERMINATOR <= `TERM_DEFAULT;
        else if (BYTE_DATA != `CHAR_NULL && BYTE_DATA != `CHAR_ESC)
          TERMINATOR <= BYTE_DATA;
      end
    end
  end

  // ==========================================================
  // Error on extra characters
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ERR_VALID <= 1'b0;
      ERR_CODE  <= 4'h0;
    end else if (CE) begin
      ERR_VALID <= st_reg == ST_DT_EXTRA && BYTE_VALID && !CMD_END;
      if (st_reg == ST_DT_EXTRA && BYTE_VALID && !CMD_END)
        ERR_CODE <= `ERR_PARAM;
    end
  end

  // ==========================================================
  // Label text routing
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DRAW_VALID <= 1'b0;
      DRAW_CHAR  <= 8'h00;
      CTRL_VALID <= 1'b0;
      CTRL_CHAR  <= 8'h00;
      LABEL_DONE <= 1'b0;
      IN_LABEL   <= 1'b0;
    end else if (CE) begin
      DRAW_VALID <= st_reg == ST_TEXT && BYTE_VALID && printing;
      CTRL_VALID <= st_reg == ST_TEXT && BYTE_VALID && !printing
                    && (!is_term || BYTE_DATA != `TERM_DEFAULT);
      LABEL_DONE <= st_reg == ST_TEXT && is_term;
      if (BYTE_VALID) begin
        DRAW_CHAR <= BYTE_DATA;
        CTRL_CHAR <= BYTE_DATA;
      end
      // Initialize in mid-label drops the label at once
      IN_LABEL <= !(OP_VALID && OP_CODE == OP_INIT)
                  && ((st_reg == ST_TEXT && !is_term)
                  || (st_reg == ST_IDLE && OP_VALID && (OP_CODE == OP_LABEL
                  || OP_CODE == OP_BUF_LABEL || OP_CODE == OP_DISP_LABEL)));
    end
  end

  cell_geometry #(.W(W)) u_geom (
    .clk    (CLK),
    .rst_n  (RST_N),
    .ce     (CE),
    .char_w (CHAR_WIDTH),
    .char_h (CHAR_HEIGHT),
    .cell_w (CELL_WIDTH_HALF),
    .cell_h (CELL_HEIGHT),
    .org_x  (ORIGIN_X),
    .org_y  (ORIGIN_Y)
  );

  // ==========================================================
  // Checks
  property p_ignore_null_esc;
    @(posedge CLK) disable iff (!RST_N)
    (CE && st_reg == ST_DT_ARG && BYTE_VALID && !CMD_END && !OP_VALID
     && (BYTE_DATA == `CHAR_NULL || BYTE_DATA == `CHAR_ESC))
    |=> TERMINATOR == $past(TERMINATOR);
  endproperty
  a_ignore_null_esc: assert property (p_ignore_null_esc)
    else $error("terminator changed by null or escape");
  property p_restore;
    @(posedge CLK) disable iff (!RST_N)
    (CE && st_reg == ST_DT_ARG && BYTE_VALID && !CMD_END
     && (BYTE_DATA == `CHAR_LF || BYTE_DATA == `CHAR_SEMI))
    |=> TERMINATOR == `TERM_DEFAULT;
  endproperty
  a_restore: assert property (p_restore)
    else $error("terminator not restored");
  property p_adopt;
    @(posedge CLK) disable iff (!RST_N)
    (CE && !OP_VALID && st_reg == ST_DT_ARG && BYTE_VALID && !CMD_END
     && BYTE_DATA != `CHAR_NULL && BYTE_DATA != `CHAR_ESC
     && BYTE_DATA != `CHAR_LF && BYTE_DATA != `CHAR_SEMI)
    |=> TERMINATOR == $past(BYTE_DATA);
  endproperty
  a_adopt: assert property (p_adopt)
    else $error("new terminator not adopted");
  property p_hold;
    @(posedge CLK) disable iff (!RST_N)
    (st_reg != ST_DT_ARG && !(OP_VALID && OP_CODE == OP_INIT))
    |=> TERMINATOR == $past(TERMINATOR);
  endproperty
  a_hold: assert property (p_hold)
    else $error("terminator changed without command");
  property p_extra_err;
    @(posedge CLK) disable iff (!RST_N)
    (CE && st_reg == ST_DT_EXTRA && BYTE_VALID && !CMD_END && !OP_VALID)
    |=> ERR_VALID && ERR_CODE == `ERR_PARAM
        && TERMINATOR == $past(TERMINATOR);
  endproperty
  a_extra_err: assert property (p_extra_err)
    else $error("extra character not flagged");
  property p_print_term;
    @(posedge CLK) disable iff (!RST_N)
    (CE && !OP_VALID && st_reg == ST_TEXT && is_term && printing)
    |=> DRAW_VALID && LABEL_DONE && DRAW_CHAR == $past(BYTE_DATA);
  endproperty
  a_print_term: assert property (p_print_term)
    else $error("printing terminator not drawn");
  property p_ctrl_term;
    @(posedge CLK) disable iff (!RST_N)
    (CE && st_reg == ST_TEXT && is_term && !printing
     && BYTE_DATA != `TERM_DEFAULT)
    |=> CTRL_VALID && LABEL_DONE && !DRAW_VALID;
  endproperty
  a_ctrl_term: assert property (p_ctrl_term)
    else $error("control terminator not executed");
  property p_only_term;
    @(posedge CLK) disable iff (!RST_N)
    (CE && st_reg == ST_TEXT && !is_term && !OP_VALID)
    |=> st_reg == ST_TEXT && !LABEL_DONE;
  endproperty
  a_only_term: assert property (p_only_term)
    else $error("label ended without terminator");
  property p_init;
    @(posedge CLK) disable iff (!RST_N)
    (CE && OP_VALID && OP_CODE == OP_INIT) |=> TERMINATOR == `TERM_DEFAULT;
  endproperty
  a_init: assert property (p_init)
    else $error("init did not restore terminator");
  c_label_done: cover property (@(posedge CLK) disable iff (!RST_N)
    LABEL_DONE);
  c_error: cover property (@(posedge CLK) disable iff (!RST_N) ERR_VALID);
  c_new_term: cover property (@(posedge CLK) disable iff (!RST_N)
    TERMINATOR != `TERM_DEFAULT ##1 LABEL_DONE);
  c_ctrl_term: cover property (@(posedge CLK) disable iff (!RST_N)
    CTRL_VALID && LABEL_DONE);
  // Bytes outside label text must never reach drawing or control
  property p_idle_bytes;
    @(posedge CLK) disable iff (!RST_N)
    (CE && st_reg == ST_IDLE && BYTE_VALID)
    |=> !DRAW_VALID && !CTRL_VALID && !LABEL_DONE;
  endproperty
  a_idle_bytes: assert property (p_idle_bytes)
    else $error("byte outside label text was routed");
  property p_init_leaves_label;
    @(posedge CLK) disable iff (!RST_N)
    (CE && OP_VALID && OP_CODE == OP_INIT)
    |=> !IN_LABEL && st_reg == ST_IDLE;
  endproperty
  a_init_leaves_label: assert property (p_init_leaves_label)
    else $error("initialize did not leave label text");
endmodule : label_terminator_cell
`default_nettype wire

// *** dv/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model
  import label_term_pkg::*;
(
  input  wire logic       clk,
  output var  logic       op_valid,
  output var  op_type     op_code,
  output var  logic       byte_valid,
  output var  logic [7:0] byte_data,
  output var  logic       cmd_end
);
  // ==========================================
  // Host side: one strobe per transfer, then one idle cycle
  initial begin
    op_valid   = 1'b0;
    op_code    = OP_NONE;
    byte_valid = 1'b0;
    byte_data  = 8'h00;
    cmd_end    = 1'b0;
  end

  task automatic send_op(input op_type o);
    @(negedge clk);
    op_valid = 1'b1;
    op_code  = o;
    @(negedge clk);
    op_valid = 1'b0;
  endtask : send_op

  // Label text must end with the active terminator; caller supplies it
  task automatic send_byte(input logic [7:0] b);
    @(negedge clk);
    byte_valid = 1'b1;
    byte_data  = b;
    @(negedge clk);
    byte_valid = 1'b0;
    // Stale data inverted so an idle bus never looks like a repeat
    byte_data  = ~b;
  endtask : send_byte

  task automatic send_end();
    @(negedge clk);
    cmd_end = 1'b1;
    @(negedge clk);
    cmd_end = 1'b0;
  endtask : send_end
endmodule : host_model
`default_nettype wire

// *** dv/label_terminator_cell_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module label_terminator_cell_tb;
  import label_term_pkg::*;
  logic        clk, rst_n, ce, op_valid, byte_valid, cmd_end;
  op_type      op_code;
  logic [7:0]  byte_data, term, draw_char, ctrl_char, last_draw, last_ctrl;
  logic        in_label, draw_valid, ctrl_valid, label_done, err_valid;
  logic [3:0]  err_code, last_err;
  logic [15:0] char_w, char_h, org_x, org_y;
  logic [17:0] cell_w2, cell_h;
  int          n_mismatch, n_checks, n_draw, n_ctrl, n_done, n_err, cyc;
  localparam logic [15:0] ROWS [7] = '{16'h2323, 16'h0023, 16'h1b23,
    16'h0a03, 16'h7878, 16'h3b03, 16'h0d0d};

  label_terminator_cell label_terminator_cell_inst (.CLK(clk), .RST_N(rst_n),
    .CE(ce), .OP_VALID(op_valid), .OP_CODE(op_code), .BYTE_VALID(byte_valid),
    .BYTE_DATA(byte_data), .CMD_END(cmd_end), .CHAR_WIDTH(char_w),
    .CHAR_HEIGHT(char_h), .TERMINATOR(term), .IN_LABEL(in_label),
    .DRAW_VALID(draw_valid), .DRAW_CHAR(draw_char), .CTRL_VALID(ctrl_valid),
    .CTRL_CHAR(ctrl_char), .LABEL_DONE(label_done), .ERR_VALID(err_valid),
    .ERR_CODE(err_code), .CELL_WIDTH_HALF(cell_w2), .CELL_HEIGHT(cell_h),
    .ORIGIN_X(org_x), .ORIGIN_Y(org_y));
  host_model host_model_inst (.clk(clk), .op_valid(op_valid),
    .op_code(op_code), .byte_valid(byte_valid), .byte_data(byte_data),
    .cmd_end(cmd_end));

  // ==========================================
  // Clock, pulse monitor, watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (draw_valid === 1'b1) begin
      n_draw++;
      last_draw = draw_char;
    end
    if (ctrl_valid === 1'b1) begin
      n_ctrl++;
      last_ctrl = ctrl_char;
    end
    if (label_done === 1'b1)
      n_done++;
    if (err_valid === 1'b1) begin
      n_err++;
      last_err = err_code;
    end
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ==========================================
  // Compare and helper tasks
  task automatic bad(input logic [31:0] g, input logic [31:0] e);
    $display("BAD %0t got %h expected %h", $time, g, e);
    n_mismatch++;
  endtask : bad
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) bad(g, e);
  endtask : chk8
  task automatic chkw(input logic [17:0] g, input logic [17:0] e);
    n_checks++;
    if (g !== e) bad(g, e);
  endtask : chkw
  task automatic chkn(input int g, input int e);
    n_checks++;
    if (g != e) bad(g, e);
  endtask : chkn
  task automatic clr();
    n_draw = 0;
    n_ctrl = 0;
    n_done = 0;
    n_err  = 0;
  endtask : clr
  task automatic def_term(input logic [7:0] b);
    host_model_inst.send_op(OP_DEF_TERM);
    host_model_inst.send_byte(b);
  endtask : def_term
  task automatic label3(input op_type o, input logic [7:0] a, b, c);
    clr();
    host_model_inst.send_op(o);
    chk8({7'h00, in_label}, 8'h01);
    host_model_inst.send_byte(a);
    host_model_inst.send_byte(b);
    host_model_inst.send_byte(c);
    repeat (2) @(negedge clk);
    chk8({7'h00, in_label}, 8'h00);
  endtask : label3
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // ==========================================
  // Main sequence
  initial begin
    rst_n      = 1'b0;
    ce         = 1'b1;
    char_w     = 16'h000a;
    char_h     = 16'h0007;
    cyc        = 0;
    n_mismatch = 0;
    n_checks   = 0;
    clr();
    repeat (6) @(negedge clk);
    chk8(term, 8'h03);
    chk8({7'h00, in_label}, 8'h00);
    rst_n = 1'b1;
    foreach (ROWS[i]) begin
      clr();
      def_term(ROWS[i][15:8]);
      host_model_inst.send_end();
      chk8(term, ROWS[i][7:0]);
      chkn(n_err, 0);
    end
    label3(OP_LABEL, 8'h41, 8'h42, 8'h0d);
    chkn(n_draw, 2);
    chkn(n_ctrl, 1);
    chk8(last_ctrl, 8'h0d);
    chkn(n_done, 1);
    ce = 1'b0;
    def_term(8'h23);
    ce = 1'b1;
    chk8(term, 8'h0d);
    clr();
    def_term(8'h6b);
    host_model_inst.send_byte(8'h7a);
    host_model_inst.send_byte(8'h79);
    host_model_inst.send_end();
    chk8(term, 8'h6b);
    chkn(n_err, 2);
    chk8({4'h0, last_err}, 8'h02);
    label3(OP_BUF_LABEL, 8'h41, 8'h42, 8'h6b);
    chkn(n_draw, 3);
    chk8(last_draw, 8'h6b);
    chkn(n_done, 1);
    host_model_inst.send_op(OP_INIT);
    @(negedge clk);
    chk8(term, 8'h03);
    label3(OP_DISP_LABEL, 8'h4c, 8'h3b, 8'h03);
    chkn(n_draw, 2);
    chk8(last_draw, 8'h3b);
    chkn(n_ctrl, 0);
    chkn(n_done, 1);
    char_w = 16'hffff;
    char_h = 16'h8001;
    repeat (2) @(negedge clk);
    chkw(cell_w2, 18'h2fffd);
    chkw(cell_h, 18'h10002);
    chkw({2'b00, org_x}, 18'h0);
    chkw({2'b00, org_y}, 18'h0);
    // Reset after the argument byte but before command end, then a label cut short by initialize
    def_term(8'h23);
    chk8(term, 8'h23);
    rst_n = 1'b0;
    @(negedge clk);
    chk8(term, 8'h03);
    rst_n = 1'b1;
    clr();
    host_model_inst.send_op(OP_LABEL);
    host_model_inst.send_byte(8'h41);
    host_model_inst.send_op(OP_INIT);
    chk8({7'h00, in_label}, 8'h00);
    host_model_inst.send_byte(8'h42);
    repeat (2) @(negedge clk);
    chkn(n_draw, 1);
    chkn(n_done, 0);
    chk8(term, 8'h03);
    stop_test();
  end
endmodule : label_terminator_cell_tb
`default_nettype wire
